/* design/rt_sa_buf_defs.svh */
// Offsets, field positions, reset values and sizes of the subaddress control register
`ifndef RT_SA_BUF_DEFS_SVH
`define RT_SA_BUF_DEFS_SVH
`define SA_CTRL_OFFSET 16'h0004
`define SA_CTRL_RESET 16'h0000
`define SA_CTRL_MASK 16'hFFE0
`define BIT_GLOBAL_SEL 15
`define BIT_TX_EOM_EN 14
`define BIT_TX_WRAP_EN 13
`define TX_CODE_HI 12
`define TX_CODE_LO 10
`define BIT_RX_EOM_EN 9
`define BIT_RX_WRAP_EN 8
`define RX_CODE_HI 7
`define RX_CODE_LO 5
`define RING_BASE_WORDS 14'h0040
`define CODE_SINGLE 3'h0
`define CODE_ALL_ONES 3'h7
`endif

/* design/rt_sa_buf_pkg.sv */
// Types shared by the subaddress buffer control register
package rt_sa_buf_pkg;
  typedef enum logic [1:0] {BUF_SINGLE, BUF_DOUBLE, BUF_RING} buf_mode_t;
  typedef struct packed {
    logic sel;
    logic wr;
    logic rd;
    logic [15:0] addr;
  } host_req_t;
  typedef struct packed {
    logic tx_eom;
    logic tx_wrap;
    logic rx_eom;
    logic rx_wrap;
  } rt_evt_t;
  typedef struct packed {
    logic dbl;
    logic ring;
  } sa_entry_t;
endpackage : rt_sa_buf_pkg

/* design/rt_subaddress_buffer_control.sv */
// Subaddress buffer control register with host port, mode decode and interrupt requests
`timescale 1ns/100ps
`default_nettype none
`include "rt_sa_buf_defs.svh"
module rt_subaddress_buffer_control (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  input wire rt_sa_buf_pkg::host_req_t HOST_REQ,
  input wire logic [15:0] HOST_DATA_IN,
  output logic [15:0] HOST_DATA_OUT,
  output logic HOST_DATA_OE_N,
  input wire logic RT_ACTIVE,
  input wire logic CW_FETCH,
  input wire logic [15:0] CW_WORD,
  input wire rt_sa_buf_pkg::sa_entry_t SA_ENTRY,
  input wire logic [2:0] GLOBAL_RING_SIZE_CODE,
  input wire rt_sa_buf_pkg::rt_evt_t RT_EVT,
  output rt_sa_buf_pkg::buf_mode_t TX_BUF_MODE,
  output logic [13:0] TX_RING_WORDS,
  output rt_sa_buf_pkg::buf_mode_t RX_BUF_MODE,
  output logic [2:0] RX_RING_SIZE_CODE,
  output logic IRQ_REQ
);
  import rt_sa_buf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Host pin synchronisers and write edge
  host_req_t req_meta;
  host_req_t req_sync;
  logic [15:0] din_meta;
  logic [15:0] din_sync;
  logic wr_seen;
  host_req_t next_req_meta;
  host_req_t next_req_sync;
  logic [15:0] next_din_meta;
  logic [15:0] next_din_sync;
  logic next_wr_seen;
  logic hit;
  logic wr_edge;

  assign hit = req_sync.sel && (req_sync.addr == `SA_CTRL_OFFSET);
  assign wr_edge = hit && req_sync.wr && !wr_seen;

  always_comb begin
    next_req_meta = req_meta;
    next_req_sync = req_sync;
    next_din_meta = din_meta;
    next_din_sync = din_sync;
    next_wr_seen = wr_seen;
    if (CE) begin
      next_req_meta = HOST_REQ;
      next_req_sync = req_meta;
      next_din_meta = HOST_DATA_IN;
      next_din_sync = din_meta;
      next_wr_seen = hit && req_sync.wr;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      req_meta <= '0;
      req_sync <= '0;
      din_meta <= 16'h0000;
      din_sync <= 16'h0000;
      wr_seen <= 1'b0;
    end else begin
      req_meta <= next_req_meta;
      req_sync <= next_req_sync;
      din_meta <= next_din_meta;
      din_sync <= next_din_sync;
      wr_seen <= next_wr_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control word register
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic [15:0] next_dout;
  logic next_oe_n;

  always_comb begin
    next_ctrl = ctrl;
    next_dout = HOST_DATA_OUT;
    next_oe_n = HOST_DATA_OE_N;
    if (CE) begin
      if (RT_ACTIVE) begin
        if (CW_FETCH) begin
          next_ctrl = CW_WORD & `SA_CTRL_MASK;
        end
      end else if (wr_edge) begin
        next_ctrl = din_sync & `SA_CTRL_MASK;
      end
      next_oe_n = !(hit && req_sync.rd);
      next_dout = (hit && req_sync.rd) ? ctrl : 16'h0000;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl <= `SA_CTRL_RESET;
      HOST_DATA_OUT <= 16'h0000;
      HOST_DATA_OE_N <= 1'b1;
    end else begin
      ctrl <= next_ctrl;
      HOST_DATA_OUT <= next_dout;
      HOST_DATA_OE_N <= next_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Buffer mode decode and interrupt requests
  logic global_buffer_select;
  logic [2:0] tx_buffer_size_code;
  logic [2:0] rx_buffer_size_code;
  logic tx_end_msg_irq_en;
  logic tx_ring_wrap_irq_en;
  logic rx_end_msg_irq_en;
  logic rx_ring_wrap_irq_en;
  buf_mode_t next_tx_mode;
  buf_mode_t next_rx_mode;
  logic [13:0] next_tx_words;
  logic [2:0] next_rx_size;
  logic next_irq;

  assign global_buffer_select = ctrl[`BIT_GLOBAL_SEL];
  assign tx_end_msg_irq_en = ctrl[`BIT_TX_EOM_EN];
  assign tx_ring_wrap_irq_en = ctrl[`BIT_TX_WRAP_EN];
  assign tx_buffer_size_code = ctrl[`TX_CODE_HI:`TX_CODE_LO];
  assign rx_end_msg_irq_en = ctrl[`BIT_RX_EOM_EN];
  assign rx_ring_wrap_irq_en = ctrl[`BIT_RX_WRAP_EN];
  assign rx_buffer_size_code = ctrl[`RX_CODE_HI:`RX_CODE_LO];

  always_comb begin
    next_tx_mode = TX_BUF_MODE;
    next_tx_words = TX_RING_WORDS;
    next_rx_mode = RX_BUF_MODE;
    next_rx_size = RX_RING_SIZE_CODE;
    next_irq = IRQ_REQ;
    if (CE) begin
      // Transmit side never looks at the global select
      if (tx_buffer_size_code == `CODE_SINGLE) begin
        next_tx_mode = BUF_SINGLE;
        next_tx_words = 14'h0000;
      end else begin
        next_tx_mode = BUF_RING;
        next_tx_words = `RING_BASE_WORDS << tx_buffer_size_code;
      end
      if (global_buffer_select) begin
        case (rx_buffer_size_code)
          `CODE_SINGLE: begin
            next_rx_mode = BUF_DOUBLE;
            next_rx_size = `CODE_SINGLE;
          end
          `CODE_ALL_ONES: begin
            next_rx_mode = BUF_RING;
            next_rx_size = GLOBAL_RING_SIZE_CODE;
          end
          default: begin
            next_rx_mode = BUF_RING;
            next_rx_size = rx_buffer_size_code;
          end
        endcase
      end else begin
        if (SA_ENTRY.ring) begin
          next_rx_mode = BUF_RING;
          next_rx_size = rx_buffer_size_code;
        end else if (SA_ENTRY.dbl) begin
          next_rx_mode = BUF_DOUBLE;
          next_rx_size = `CODE_SINGLE;
        end else begin
          next_rx_mode = BUF_SINGLE;
          next_rx_size = `CODE_SINGLE;
        end
      end
      next_irq = (RT_EVT.tx_eom && tx_end_msg_irq_en)
        || (RT_EVT.tx_wrap && tx_ring_wrap_irq_en)
        || (RT_EVT.rx_eom && rx_end_msg_irq_en)
        || (RT_EVT.rx_wrap && rx_ring_wrap_irq_en);
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      TX_BUF_MODE <= BUF_SINGLE;
      TX_RING_WORDS <= 14'h0000;
      RX_BUF_MODE <= BUF_SINGLE;
      RX_RING_SIZE_CODE <= 3'h0;
      IRQ_REQ <= 1'b0;
    end else begin
      TX_BUF_MODE <= next_tx_mode;
      TX_RING_WORDS <= next_tx_words;
      RX_BUF_MODE <= next_rx_mode;
      RX_RING_SIZE_CODE <= next_rx_size;
      IRQ_REQ <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  active_write_block_a: assert property (
    CE && RT_ACTIVE && !CW_FETCH |=> $stable(ctrl))
    else $error("control word changed while active without fetch");
  fetch_load_a: assert property (
    CE && RT_ACTIVE && CW_FETCH |=> ctrl == ($past(CW_WORD) & `SA_CTRL_MASK))
    else $error("fetched control word not loaded");
  idle_write_a: assert property (
    CE && !RT_ACTIVE && wr_edge |=> ctrl == ($past(din_sync) & `SA_CTRL_MASK))
    else $error("idle host write not taken");
  global_rx_double_a: assert property (
    CE && global_buffer_select && rx_buffer_size_code == 3'h0 |=> RX_BUF_MODE == BUF_DOUBLE)
    else $error("global double buffering not selected");
  global_rx_ring_a: assert property (
    CE && global_buffer_select && rx_buffer_size_code == 3'h7
    |=> RX_BUF_MODE == BUF_RING && RX_RING_SIZE_CODE == $past(GLOBAL_RING_SIZE_CODE))
    else $error("global ring size not taken from configuration");
  per_sa_mode_a: assert property (
    CE && !global_buffer_select && SA_ENTRY.dbl && !SA_ENTRY.ring |=> RX_BUF_MODE == BUF_DOUBLE)
    else $error("per-subaddress double buffering not followed");
  tx_single_a: assert property (
    CE && tx_buffer_size_code == 3'h0 |=> TX_BUF_MODE == BUF_SINGLE && TX_RING_WORDS == 14'h0000)
    else $error("transmit single buffering not selected");
  tx_ring_size_a: assert property (
    CE && tx_buffer_size_code == 3'h7 |=> TX_BUF_MODE == BUF_RING && TX_RING_WORDS == 14'h2000)
    else $error("transmit ring of 8192 words not selected");
  tx_eom_irq_a: assert property (
    CE && RT_EVT.tx_eom && tx_end_msg_irq_en |=> IRQ_REQ)
    else $error("transmit end of message interrupt missing");
  rx_wrap_irq_a: assert property (
    CE && RT_EVT.rx_wrap && rx_ring_wrap_irq_en |=> IRQ_REQ)
    else $error("receive wrap interrupt missing");
  no_irq_a: assert property (
    CE && !(RT_EVT.tx_wrap && tx_ring_wrap_irq_en) && !(RT_EVT.tx_eom && tx_end_msg_irq_en)
    && !(RT_EVT.rx_eom && rx_end_msg_irq_en) && !(RT_EVT.rx_wrap && rx_ring_wrap_irq_en) |=> !IRQ_REQ)
    else $error("interrupt raised without enabled event");

  idle_write_c: cover property (CE && !RT_ACTIVE && wr_edge);
  fetch_c: cover property (CE && RT_ACTIVE && CW_FETCH);
  global_ring_c: cover property (RX_BUF_MODE == BUF_RING && global_buffer_select);
  irq_c: cover property (IRQ_REQ);
endmodule : rt_subaddress_buffer_control
`default_nettype wire

/* tb/host_bfm.sv */
// Host processor model on the parallel host bus pins
`timescale 1ns/100ps
`default_nettype none
module host_bfm (
  input wire logic MCLK,
  output rt_sa_buf_pkg::host_req_t HOST_REQ,
  output logic [15:0] HOST_DATA_IN,
  input wire logic [15:0] HOST_DATA_OUT,
  input wire logic HOST_DATA_OE_N
);
  import rt_sa_buf_pkg::*;
  initial begin
    HOST_REQ = '0;
    HOST_DATA_IN = 16'hFFFF;
  end
  task automatic cycle(input host_req_t req, input logic [15:0] d, input int hold);
    @(posedge MCLK);
    #1;
    HOST_REQ = req;
    HOST_DATA_IN = d;
    repeat (hold) @(posedge MCLK);
  endtask : cycle
  // Strobe held long enough for the pin synchronisers, then dropped
  task automatic bus_write(input logic [15:0] addr, input logic [15:0] d);
    cycle('{1'b1, 1'b1, 1'b0, addr}, d, 4);
    cycle('0, ~d, 4);
    // Hand back off the edge so callers never race the design's flops
    #1;
  endtask : bus_write
  // Undriven data lines show the inverse of the last value
  task automatic bus_read(input logic [15:0] addr, output logic [15:0] d, output logic oe_n);
    cycle('{1'b1, 1'b0, 1'b1, addr}, ~HOST_DATA_IN, 4);
    #1;
    d = HOST_DATA_OUT;
    oe_n = HOST_DATA_OE_N;
    cycle('0, ~HOST_DATA_IN, 4);
    #1;
  endtask : bus_read
endmodule : host_bfm
`default_nettype wire

/* tb/rt_subaddress_buffer_control_tb.sv */
// Self-checking bench of the subaddress buffer control register
`timescale 1ns/100ps
`default_nettype none
`include "rt_sa_buf_defs.svh"
module rt_subaddress_buffer_control_tb;
  import rt_sa_buf_pkg::*;
  logic mclk = 0, rst = 1, rt_active = 0, cw_fetch = 0, irq_req, oe_n, rd_oe;
  logic [15:0] data_in, data_out, cw_word = 16'h0, rd, d, exp_reg;
  logic [2:0] ring_code = 3'h0, rx_size;
  logic [13:0] tx_words;
  host_req_t host_req;
  sa_entry_t sa_entry = '0;
  rt_evt_t rt_evt = '0;
  buf_mode_t tx_mode, rx_mode;
  int n_mismatch = 0, n_checks = 0;
  rt_subaddress_buffer_control u_rt_subaddress_buffer_control (.MCLK(mclk), .RST(rst), .CE(1'b1),
    .HOST_REQ(host_req), .HOST_DATA_IN(data_in), .HOST_DATA_OUT(data_out), .HOST_DATA_OE_N(oe_n),
    .RT_ACTIVE(rt_active), .CW_FETCH(cw_fetch), .CW_WORD(cw_word), .SA_ENTRY(sa_entry),
    .GLOBAL_RING_SIZE_CODE(ring_code), .RT_EVT(rt_evt), .TX_BUF_MODE(tx_mode),
    .TX_RING_WORDS(tx_words), .RX_BUF_MODE(rx_mode), .RX_RING_SIZE_CODE(rx_size), .IRQ_REQ(irq_req));
  host_bfm u_host_bfm (.MCLK(mclk), .HOST_REQ(host_req), .HOST_DATA_IN(data_in),
    .HOST_DATA_OUT(data_out), .HOST_DATA_OE_N(oe_n));
  initial begin
    forever #4 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // Read back and compare against the bench copy of the register
  task automatic read_check();
    u_host_bfm.bus_read(`SA_CTRL_OFFSET, rd, rd_oe);
    check({15'h0, rd_oe}, 16'h0000);
    check(rd, exp_reg);
  endtask : read_check
  task automatic pulse_evt(input logic [3:0] e);
    @(posedge mclk);
    #1;
    rt_evt = e;
    @(posedge mclk);
    #1;
    rt_evt = '0;
    check({15'h0, irq_req}, {15'h0, |(e & {exp_reg[14:13], exp_reg[9:8]})});
  endtask : pulse_evt
  function automatic logic [15:0] rx_exp(input logic [15:0] r);
    if (r[15]) return (r[7:5] == 3'h0) ? BUF_DOUBLE : BUF_RING;
    return sa_entry.ring ? BUF_RING : (sa_entry.dbl ? BUF_DOUBLE : BUF_SINGLE);
  endfunction : rx_exp
  ////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    void'($urandom(86));
    exp_reg = `SA_CTRL_RESET;
    repeat (5) @(posedge mclk);
    #1;
    rst = 0;
    check({14'h0, tx_mode}, BUF_SINGLE);
    read_check();
    u_host_bfm.bus_read(16'h0006, rd, rd_oe);
    check(rd, 16'h0000);
    check({15'h0, rd_oe}, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom);
      d[12:10] = 3'(i);
      d[7:5] = 3'(7 - i);
      d[15] = (i == 0 || i == 7 || i == 4);
      sa_entry = 2'($urandom);
      ring_code = 3'($urandom);
      u_host_bfm.bus_write(`SA_CTRL_OFFSET, d);
      exp_reg = d & `SA_CTRL_MASK;
      check({14'h0, tx_mode}, (i == 0) ? BUF_SINGLE : BUF_RING);
      check({2'h0, tx_words}, (i == 0) ? 16'h0000 : (16'h0080 << (i - 1)));
      check({14'h0, rx_mode}, rx_exp(exp_reg));
      if (d[15] && i == 0) check({13'h0, rx_size}, {13'h0, ring_code});
      for (int j = 0; j < 4; j++) pulse_evt(4'h8 >> j);
      read_check();
    end
    rt_active = 1;
    u_host_bfm.bus_write(`SA_CTRL_OFFSET, ~exp_reg);
    read_check();
    @(posedge mclk);
    #1;
    cw_fetch = 1;
    cw_word = 16'($urandom);
    @(posedge mclk);
    #1;
    cw_fetch = 0;
    exp_reg = cw_word & `SA_CTRL_MASK;
    read_check();
    rt_active = 0;
    print_verdict();
  end
endmodule : rt_subaddress_buffer_control_tb
`default_nettype wire
